// >>> logic/tqd_top.sv
`include "tqd_consts.svh"
`default_nettype none
module tqd_top #(
  parameter int AXES = 3
) (
  input  wire logic              I_REF_CLK,
  input  wire logic              I_SYS_RST,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [31:0]       PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  input  wire tqd_pkg::tqd_pins_t I_PAIRS,
  input  wire logic              I_LOW_POWER_CLOCK,
  output logic                   O_IRQ
);
  import tqd_pkg::*;

  initial begin
    if (AXES != 3) $error("tqd_top serves exactly three axes");
  end

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic sel_valid(input logic [3:0] s);
    return (s != 4'h0) && (s <= `TQD_SEL_MAX);
  endfunction : sel_valid

  function automatic logic [1:0] pick_pair(input tqd_pins_t p, input logic [3:0] s);
    logic [3:0] idx;
    idx = s - 4'h1;
    if (!sel_valid(s)) return 2'b00;
    return {p.first[idx], p.second[idx]};
  endfunction : pick_pair

  // returns +1, -1 or 0
  function automatic logic signed [1:0] step_of(input logic em, input logic [1:0] pv, input logic [1:0] cv);
    if (em) return (pv != cv) ? 2'sd1 : 2'sd0;
    unique case ({pv, cv})
      4'b0001, 4'b0111, 4'b1110, 4'b1000: return 2'sd1;
      4'b0010, 4'b1011, 4'b1101, 4'b0100: return -2'sd1;
      // no change, or a double step whose direction is unknown
      default: return 2'sd0;
    endcase
  endfunction : step_of

  //////////////////////////////////////////////////////////////////////////////
  logic [7:0]          thres;
  logic                pending;
  logic                unmask;
  logic                halve;
  logic [9:0]          div;
  tqd_axis_cfg_t [2:0] cfg;
  logic [2:0][15:0]    pos;
  logic [7:0]          total;
  tqd_pins_t           sync1;
  tqd_pins_t           sync2;
  logic [9:0]          div_cnt;
  logic                half;
  logic                tick;
  logic [2:0][1:0]     prev;
  logic [2:0][1:0]     cur;
  logic [2:0]          ev;
  logic signed [1:0]   stp [3];
  logic [1:0]          n_events;
  logic [7:0]          next_total;
  logic                set_irq;
  logic                wr;
  logic                evclr;
  logic                pend_clr;

  assign wr       = PSEL && PENABLE && PWRITE && PREADY;
  assign evclr    = wr && (PADDR == `TQD_CTRL_ADDR) && PWDATA[`TQD_EVCLR_BIT];
  assign pend_clr = wr && (PADDR == `TQD_CTRL_ADDR) && PWDATA[`TQD_PEND_BIT];

  //////////////////////////////////////////////////////////////////////////////
  // apb slave: pready raised in setup, so every access completes in one cycle
  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end else begin
      PREADY  <= PSEL && !PENABLE;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      if (PSEL && !PENABLE) begin
        unique case (PADDR)
          // clear bit always reads zero
          `TQD_CTRL_ADDR:  PRDATA <= {21'h0, thres, pending, 1'b0, unmask};
          `TQD_XCNT_ADDR:  PRDATA <= {16'h0000, pos[0]};
          `TQD_YCNT_ADDR:  PRDATA <= {16'h0000, pos[1]};
          `TQD_DIV_ADDR:   PRDATA <= {21'h0, halve, div};
          `TQD_SEL_ADDR:   PRDATA <= {17'h0, cfg[2].edge_mode, cfg[1].edge_mode, cfg[0].edge_mode,
                                      cfg[2].sel, cfg[1].sel, cfg[0].sel};
          `TQD_ZCNT_ADDR:  PRDATA <= {16'h0000, pos[2]};
          `TQD_EVCNT_ADDR: PRDATA <= {24'h00_0000, total};
          // unmapped: error answer, any write there is dropped
          default:         PSLVERR <= 1'b1;
        endcase
      end
    end
  end

  // software-owned configuration
  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      thres         <= `TQD_THRES_RST;
      unmask        <= 1'b0;
      halve         <= 1'b0;
      div           <= `TQD_DIV_RST;
      cfg[0]        <= '{edge_mode: 1'b1, sel: `TQD_SEL_X_RST};
      cfg[1]        <= '{edge_mode: 1'b1, sel: `TQD_SEL_Y_RST};
      cfg[2]        <= '{edge_mode: 1'b1, sel: `TQD_SEL_Z_RST};
    end else if (wr) begin
      if (PADDR == `TQD_CTRL_ADDR) begin
        thres  <= PWDATA[`TQD_THRES_MSB:`TQD_THRES_LSB];
        unmask <= PWDATA[`TQD_UNMASK_BIT];
      end
      if (PADDR == `TQD_DIV_ADDR) begin
        halve <= PWDATA[`TQD_HALVE_BIT];
        div   <= PWDATA[`TQD_DIV_MSB:0];
      end
      if (PADDR == `TQD_SEL_ADDR) begin
        for (int k = 0; k < 3; k++) begin
          cfg[k].sel       <= PWDATA[k*`TQD_SEL_W +: `TQD_SEL_W];
          cfg[k].edge_mode <= PWDATA[`TQD_MODE_LSB + k];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sample tick: divide by div+1, bypassed on the low power clock, then halved
  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      div_cnt <= 10'h000;
      half    <= 1'b0;
      tick    <= 1'b0;
    end else begin
      tick <= 1'b0;
      // halving keeps its phase across divider changes, so the first halved tick may come one wrap late
      if (I_LOW_POWER_CLOCK || div_cnt >= div) begin
        div_cnt <= 10'h000;
        half    <= !half;
        tick    <= !halve || half;
      end else begin
        div_cnt <= div_cnt + 10'h001;
      end
    end
  end

  // two flops per pin; only the second is read
  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= I_PAIRS;
      sync2 <= sync1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    // three axes give at most three events per tick
    n_events = 2'b00;
    for (int k = 0; k < 3; k++) begin
      cur[k] = pick_pair(sync2, cfg[k].sel);
      stp[k] = step_of(cfg[k].edge_mode, prev[k], cur[k]);
      ev[k]  = tick && sel_valid(cfg[k].sel) && (stp[k] != 2'sd0);
      n_events = n_events + {1'b0, ev[k]};
    end
    // clearing and counting in one cycle keeps the new events
    next_total = (evclr ? 8'h00 : total) + {6'h00, n_events};
    set_irq    = (n_events != 2'b00) && ({1'b0, next_total} >= ({1'b0, thres} + 9'h001));
  end

  // samples and positions: cleared every cycle while the axis is disabled, else updated on the sample tick only
  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      prev <= '0;
      pos  <= '0;
    end else begin
      for (int k = 0; k < 3; k++) begin
        if (!sel_valid(cfg[k].sel)) begin
          // forget the last sample so re-enabling starts from a clean 00
          pos[k]  <= 16'h0000;
          prev[k] <= 2'b00;
        end else if (tick) begin
          prev[k] <= cur[k];
          pos[k]  <= pos[k] + {{14{stp[k][1]}}, stp[k]};
        end
      end
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      total <= 8'h00;
    end else begin
      total <= next_total;
    end
  end

  // status: a set in the clearing cycle wins
  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      pending <= 1'b0;
      O_IRQ   <= 1'b0;
    end else begin
      pending <= set_irq || (pending && !pend_clr);
      O_IRQ   <= (set_irq || (pending && !pend_clr)) && (wr && PADDR == `TQD_CTRL_ADDR ?
                   PWDATA[`TQD_UNMASK_BIT] : unmask);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  logic [1:0] x_both;
  assign x_both = prev[0] ^ cur[0];

  // bus handshake: zero wait states, one-cycle answer
  pready_once_a: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    (PSEL && !PENABLE) |=> PREADY) else $error("ready missing after setup");

  pready_only_a: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    !(PSEL && !PENABLE) |=> !PREADY) else $error("ready without setup");

  pslverr_ready_a: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    PSLVERR |-> PREADY) else $error("error answer without ready");

  // interrupt path
  irq_follows_a: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    O_IRQ |-> pending && unmask) else $error("irq high without unmasked pending");

  irq_set_a: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    set_irq |=> pending ##0 total >= thres + 8'h01) else $error("threshold reached but no pending");

  pend_w1c_a: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    (pend_clr && !set_irq) |=> !pending) else $error("pending not cleared by write of one");

  pend_hold_a: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    (pending && !pend_clr) |=> pending) else $error("pending lost without clear");

  irq_masked_a: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    !unmask |-> !O_IRQ) else $error("irq high while masked");

  // event total
  evclr_zero_a: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    (evclr && n_events == 2'b00) |=> total == 8'h00 ##1 PRDATA[1] == 1'b0) else $error("event total not cleared");

  evclr_read_a: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    (PREADY && !PWRITE && PADDR == `TQD_CTRL_ADDR) |-> !PRDATA[`TQD_EVCLR_BIT]) else $error("clear bit read one");

  total_hold_a: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    (!evclr && n_events == 2'b00) |=> $stable(total)) else $error("event total moved without events");

  total_inc_a: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    (!evclr && n_events == 2'b01) |=> total == $past(total) + 8'h01) else $error("event total not stepped");

  // axis counts and channel selection
  off_zero_a: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    !sel_valid(cfg[0].sel) |=> pos[0] == 16'h0000) else $error("disabled axis count not zero");

  off_zero_y_a: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    !sel_valid(cfg[1].sel) |=> pos[1] == 16'h0000) else $error("disabled y count not zero");

  off_zero_z_a: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    !sel_valid(cfg[2].sel) |=> pos[2] == 16'h0000) else $error("disabled z count not zero");

  code_high_a: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    (cfg[0].sel > `TQD_SEL_MAX) |-> !ev[0]) else $error("high select code counted");

  cfg_write_a: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    (wr && PADDR == `TQD_SEL_ADDR) |=> cfg[0].sel == $past(PWDATA[3:0])) else $error("select not written");

  sync_chain_a: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    1'b1 |=> sync2 == $past(sync1)) else $error("synchroniser stage skipped");

  // decoding
  edge_one_a: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    (tick && sel_valid(cfg[0].sel) && cfg[0].edge_mode && x_both == 2'b11)
      |=> pos[0] == $past(pos[0]) + 16'h0001) else $error("double edge did not count one");

  edge_step_y_a: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    (tick && sel_valid(cfg[1].sel) && cfg[1].edge_mode && prev[1] != cur[1])
      |=> pos[1] == $past(pos[1]) + 16'h0001) else $error("y edge not counted");

  edge_step_z_a: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    (tick && sel_valid(cfg[2].sel) && cfg[2].edge_mode && prev[2] != cur[2])
      |=> pos[2] == $past(pos[2]) + 16'h0001) else $error("z edge not counted");

  quad_up_a: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    (tick && sel_valid(cfg[0].sel) && !cfg[0].edge_mode && prev[0] == 2'b00 && cur[0] == 2'b01)
      |=> pos[0] == $past(pos[0]) + 16'h0001) else $error("quadrature up not counted");

  quad_dn_a: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    (tick && sel_valid(cfg[0].sel) && !cfg[0].edge_mode && prev[0] == 2'b01 && cur[0] == 2'b00)
      |=> pos[0] == $past(pos[0]) - 16'h0001) else $error("quadrature down not counted");

  quad_skip_a: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    (tick && sel_valid(cfg[0].sel) && !cfg[0].edge_mode && x_both == 2'b11) |=> $stable(pos[0])) else $error("double step counted");

  // sample tick
  lp_tick_a: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    (I_LOW_POWER_CLOCK && !halve)[*2] |=> tick) else $error("divider not bypassed");

  halve_gap_a: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    (tick && halve && $stable(halve)) |=> !tick) else $error("halved tick too fast");

  div_gap_a: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    (tick && !I_LOW_POWER_CLOCK && div == 10'h002 && $stable(div)) |=> !tick[*2])
    else $error("divided tick too fast");

  // main scenarios
  quad_up_c: cover property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    ev[0] && !cfg[0].edge_mode && stp[0] == 2'sd1);
  quad_dn_c: cover property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    ev[1] && !cfg[1].edge_mode && stp[1] == -2'sd1);
  irq_out_c: cover property (@(posedge I_REF_CLK) disable iff (I_SYS_RST) $rose(O_IRQ));
  halve_tick_c: cover property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    tick && halve);
  edge_double_c: cover property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
    ev[0] && cfg[0].edge_mode && x_both == 2'b11);
endmodule : tqd_top
`default_nettype wire

// >>> logic/tqd_consts.svh
`ifndef TQD_CONSTS_SVH
`define TQD_CONSTS_SVH
// register byte addresses
`define TQD_CTRL_ADDR     32'h5000_0500
`define TQD_XCNT_ADDR     32'h5000_0504
`define TQD_YCNT_ADDR     32'h5000_0508
`define TQD_DIV_ADDR      32'h5000_050C
`define TQD_SEL_ADDR      32'h5000_0510
`define TQD_ZCNT_ADDR     32'h5000_0514
`define TQD_EVCNT_ADDR    32'h5000_0518
// decoder_control fields
`define TQD_THRES_LSB     3
`define TQD_THRES_MSB     10
`define TQD_PEND_BIT      2
`define TQD_EVCLR_BIT     1
`define TQD_UNMASK_BIT    0
`define TQD_THRES_RST     8'h02
// sample_clock_divider fields
`define TQD_HALVE_BIT     10
`define TQD_DIV_MSB       9
`define TQD_DIV_RST       10'h3E7
// port_select_and_mode fields
`define TQD_MODE_LSB      12
`define TQD_SEL_W         4
`define TQD_SEL_X_RST     4'h1
`define TQD_SEL_Y_RST     4'h2
`define TQD_SEL_Z_RST     4'h3
`define TQD_SEL_MAX       4'hC
`endif

// >>> logic/tqd_pkg.sv
`default_nettype none
package tqd_pkg;
  // one phase pair per selectable input code, index = code - 1
  typedef struct packed {
    logic [11:0] first;
    logic [11:0] second;
  } tqd_pins_t;

  typedef struct packed {
    logic       edge_mode;
    logic [3:0] sel;
  } tqd_axis_cfg_t;
endpackage : tqd_pkg
`default_nettype wire

// >>> tb/tqd_encoder_model.sv
`default_nettype none
module tqd_encoder_model (
  input  wire logic               i_clk,
  output var  tqd_pkg::tqd_pins_t o_pairs
);
  import tqd_pkg::*;
  int pos [12];
  initial begin
    o_pairs = '0;
  end
  // gray order 00,01,11,10 counts up; delta 2 makes an illegal double step
  task automatic move(input int idx, input int delta);
    @(posedge i_clk);
    pos[idx] = pos[idx] + delta;
    o_pairs.first[idx] <= pos[idx][1];
    o_pairs.second[idx] <= pos[idx][1] ^ pos[idx][0];
  endtask : move
endmodule : tqd_encoder_model
`default_nettype wire

// >>> tb/test_three_axis_quadrature_decoder.sv
`include "tqd_consts.svh"
`default_nettype none
module test_three_axis_quadrature_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  import tqd_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        lp = 1'b1;
  logic        irq;
  tqd_pins_t   pairs;
  int          n_errors = 0;
  int          tests_run = 0;
  always #5 clk = ~clk;
  tqd_top DUT (.I_REF_CLK(clk), .I_SYS_RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .I_PAIRS(pairs), .I_LOW_POWER_CLOCK(lp), .O_IRQ(irq));
  tqd_encoder_model enc (.i_clk(clk), .o_pairs(pairs));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t %s: got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) chk(32'h0, 32'h1, "no ready");
  endtask : apb
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string what);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp, what);
  endtask : rd
  // sync, tick and count update need about four cycles; eight leaves margin
  task automatic step(input int idx, input int delta);
    enc.move(idx, delta);
    repeat (8) @(posedge clk);
  endtask : step
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [31:0] r;
    logic        e;
    rd(`TQD_CTRL_ADDR, 32'h0000_0010, "ctrl reset");
    rd(`TQD_DIV_ADDR, 32'h0000_03E7, "div reset");
    rd(`TQD_SEL_ADDR, 32'h0000_7321, "select reset");
    rd(`TQD_EVCNT_ADDR, 32'h0, "total reset");
    wr(`TQD_XCNT_ADDR, 32'h0000_1234);
    rd(`TQD_XCNT_ADDR, 32'h0, "x read only");
    apb(1'b1, 32'h5000_051C, 32'hFFFF_FFFF, r, e);
    chk({31'h0, e}, 32'h1, "unmapped error");
    $display("test reset done");
  endtask : t_reset
  task automatic t_quad;
    wr(`TQD_SEL_ADDR, 32'h0000_6321);
    repeat (3) step(0, 1);
    step(0, -1);
    step(0, 2);
    repeat (5) step(0, -1);
    rd(`TQD_XCNT_ADDR, 32'h0000_FFFD, "x quadrature");
    $display("test quadrature done");
  endtask : t_quad
  task automatic t_edge;
    step(1, 1);
    step(1, 2);
    step(1, 1);
    rd(`TQD_YCNT_ADDR, 32'h0000_0003, "y edges");
    $display("test edge mode done");
  endtask : t_edge
  task automatic t_disable;
    wr(`TQD_SEL_ADDR, 32'h0000_6320);
    rd(`TQD_XCNT_ADDR, 32'h0, "x code zero");
    wr(`TQD_SEL_ADDR, 32'h0000_632D);
    rd(`TQD_SEL_ADDR, 32'h0000_632D, "select readback");
    rd(`TQD_XCNT_ADDR, 32'h0, "x code thirteen");
    $display("test disable done");
  endtask : t_disable
  task automatic t_irq;
    wr(`TQD_CTRL_ADDR, 32'h0000_0016);
    rd(`TQD_CTRL_ADDR, 32'h0000_0010, "clear bit reads zero");
    rd(`TQD_EVCNT_ADDR, 32'h0, "total cleared");
    step(2, 1);
    step(2, 1);
    rd(`TQD_CTRL_ADDR, 32'h0000_0010, "below threshold");
    wr(`TQD_CTRL_ADDR, 32'h0000_0011);
    step(2, 1);
    chk({31'h0, irq}, 32'h1, "irq at threshold");
    rd(`TQD_EVCNT_ADDR, 32'h0000_0003, "total three");
    wr(`TQD_CTRL_ADDR, 32'h0000_0010);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0, "irq masked");
    rd(`TQD_CTRL_ADDR, 32'h0000_0014, "still pending");
    wr(`TQD_CTRL_ADDR, 32'h0000_0015);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    rd(`TQD_CTRL_ADDR, 32'h0000_0011, "pending cleared");
    $display("test interrupt done");
  endtask : t_irq
  // halved tick with the divider bypassed; x back in edge mode sees one double change
  task automatic t_halve;
    wr(`TQD_DIV_ADDR, 32'h0000_0400);
    rd(`TQD_DIV_ADDR, 32'h0000_0400, "halve readback");
    wr(`TQD_SEL_ADDR, 32'h0000_7321);
    repeat (8) @(posedge clk);
    step(0, 2);
    step(1, 1);
    rd(`TQD_XCNT_ADDR, 32'h0000_0002, "x edges halved");
    rd(`TQD_YCNT_ADDR, 32'h0000_0004, "y edge halved");
    wr(`TQD_SEL_ADDR, 32'h0000_632D);
    wr(`TQD_DIV_ADDR, 32'h0000_03E7);
    $display("test prescaler done");
  endtask : t_halve
  // divider in use again: one count must wait for a slow tick of 1000 cycles
  task automatic t_div;
    @(posedge clk);
    lp <= 1'b0;
    step(0, 3);
    wr(`TQD_SEL_ADDR, 32'h0000_6321);
    step(0, 1);
    repeat (1010) @(posedge clk);
    rd(`TQD_XCNT_ADDR, 32'h0000_0001, "x slow tick");
    $display("test divider done");
  endtask : t_div
  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    final_report();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_quad();
    t_edge();
    t_disable();
    t_irq();
    t_halve();
    t_div();
    final_report();
  end
endmodule : test_three_axis_quadrature_decoder
`default_nettype wire
